/* hdl/sdram_command_interface.sv */
/*
  device side of a four-bank synchronous dram: command decode, bank and row
  state, burst engine, read latency pipeline, byte masks, power states and a
  small wishbone status port.
  assumes all pins synchronous to ref_clk and a controller that keeps the
  refresh budget and the dram timing between commands.
*/
// What this block does
// - all pins sampled on rising ref_clk
// - four banks of rows by columns, 16-bit words
// - row must be opened before read or write
// - open command: bank pins and row address
// - low address bits start column, bit ten autoclose
// - precharge bit ten high closes all banks
// - bank pins name target of bank commands
// - burst lengths 1,2,4,8 or full page
// - sequential or interleaved column order
// - burst stop or precharge of its bank ends burst early
// - burst reads with single-word writes mode
// - read data after latency two or three
// - new column accepted every cycle
// - auto precharge closes row after burst
// - precharge one bank while another bursts
// - config load stores address as mode
// - edge ignored when clock enable was low at the edge before
// - low enable: power-down, suspend or self refresh
// - chip select high ignores commands
// - read mask high floats its byte
// - write mask high blocks its byte
`timescale 1ns/10ps
module sdram_command_interface #(
  parameter int ROW_BITS = sdram_pkg::ROW_BITS_DEF,
  parameter int COL_BITS = sdram_pkg::COL_BITS_DEF,
  parameter int DATA_BITS = sdram_pkg::DATA_BITS_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [ROW_BITS-1:0] row_col_addr_in,
  input wire logic [DATA_BITS-1:0] data_io_bus_in,
  output logic [DATA_BITS-1:0] data_io_bus_out,
  output logic [1:0] data_io_bus_oe,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [7:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbWeI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  output logic [31:0] wbDatO,
  output logic wbAckO
);
  import sdram_pkg::*;

  localparam int WORDS = BANK_COUNT * (2 ** ROW_BITS) * (2 ** COL_BITS);
  localparam int IDX_BITS = 2 + ROW_BITS + COL_BITS;
  localparam int HALF = DATA_BITS / 2;
  localparam logic [COL_BITS:0] FULL_LEN = (COL_BITS + 1)'(2 ** COL_BITS);
  localparam logic [COL_BITS:0] ONE_LEN = (COL_BITS + 1)'(1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // chip select high forces a no-op
  function automatic cmd_t decodeCmd(input logic cs, input logic ras, input logic cas,
                                     input logic we);
    cmd_t c;
    c = CMD_NOP;
    if (!cs) begin
      case ({ras, cas, we})
        3'b011: c = CMD_ACTIVE;
        3'b101: c = CMD_READ;
        3'b100: c = CMD_WRITE;
        3'b110: c = CMD_BURST_STOP;
        3'b010: c = CMD_PRECHARGE;
        3'b001: c = CMD_REFRESH;
        3'b000: c = CMD_CONFIG_LOAD;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [COL_BITS:0] burstLenOf(input logic [2:0] code);
    logic [COL_BITS:0] len;
    case (code)
      3'h0: len = ONE_LEN;
      3'h1: len = (COL_BITS + 1)'(2);
      3'h2: len = (COL_BITS + 1)'(4);
      3'h3: len = (COL_BITS + 1)'(8);
      BL_CODE_FULL: len = FULL_LEN;
      default: len = ONE_LEN;
    endcase
    return len;
  endfunction

  // column of beat idx; wraps inside the aligned block of the burst
  function automatic logic [COL_BITS-1:0] burstCol(input logic [COL_BITS-1:0] start,
      input logic [COL_BITS:0] idx, input logic [COL_BITS:0] len, input logic il);
    logic [COL_BITS-1:0] mask;
    logic [COL_BITS-1:0] step;
    mask = COL_BITS'(len - ONE_LEN);
    step = idx[COL_BITS-1:0];
    if (il) begin
      return (start & ~mask) | ((start ^ step) & mask);
    end
    return (start & ~mask) | (COL_BITS'(start + step) & mask);
  endfunction

  function automatic logic [IDX_BITS-1:0] memIdx(input logic [1:0] bank,
      input logic [ROW_BITS-1:0] row, input logic [COL_BITS-1:0] col);
    return {bank, row, col};
  endfunction

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic ckePrev_ff;
  pwr_t pwrState_ff;
  logic [11:0] modeReg_ff;
  logic [BANK_COUNT-1:0] rowOpen_ff;
  logic [ROW_BITS-1:0] openRow_ff [BANK_COUNT];
  logic bstActive_ff;
  logic bstWrite_ff;
  logic bstAutoPre_ff;
  logic bstIl_ff;
  logic [1:0] bstBank_ff;
  logic [COL_BITS-1:0] bstStart_ff;
  logic [COL_BITS:0] bstIdx_ff;
  logic [COL_BITS:0] bstLen_ff;
  logic [DATA_BITS-1:0] mem [WORDS];
  logic [DATA_BITS-1:0] rdWord_ff;
  logic p1Valid_ff;
  logic p2Valid_ff;
  logic [DATA_BITS-1:0] p2Data_ff;
  logic outValid_ff;
  logic [15:0] refCount_ff;

  // ----------------------------------------------------------------
  // clock enable and command decode
  // ----------------------------------------------------------------
  // enable seen at one edge qualifies the next edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev_ff <= 1'b0;
    end else begin
      ckePrev_ff <= cke;
    end
  end

  logic edgeValid;
  logic [1:0] bankSel;
  logic addrTen;
  cmd_t cmdNow;
  assign edgeValid = ckePrev_ff;
  assign bankSel = {bank_select_hi, bank_select_lo};
  assign addrTen = row_col_addr_in[AUTO_CLOSE_ALL_BANKS_BIT];
  assign cmdNow = edgeValid ? decodeCmd(csN, rasN, casN, weN) : CMD_NOP;

  // mode fields
  logic [2:0] modeBl;
  logic modeIl;
  logic clIs2;
  logic modeWb;
  assign modeBl = modeReg_ff[MODE_BL_LSB +: MODE_BL_W];
  assign modeIl = modeReg_ff[MODE_BT_BIT];
  assign clIs2 = modeReg_ff[MODE_CL_LSB +: MODE_CL_W] == CL_CODE_TWO;
  assign modeWb = modeReg_ff[MODE_WB_BIT];

  // ----------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------
  // a new column command to an open bank preempts any running burst
  logic startAcc;
  logic startWr;
  logic stopNow;
  logic contAcc;
  logic accOn;
  logic accWr;
  logic lastAcc;
  logic closeAuto;
  logic [1:0] accBank;
  logic [COL_BITS-1:0] accCol;
  logic [COL_BITS:0] newLen;
  logic [IDX_BITS-1:0] accIdx;
  logic [COL_BITS:0] idxNext;
  assign startAcc = (cmdNow == CMD_READ || cmdNow == CMD_WRITE) && rowOpen_ff[bankSel];
  assign startWr = startAcc && cmdNow == CMD_WRITE;
  assign stopNow = cmdNow == CMD_BURST_STOP || (cmdNow == CMD_PRECHARGE &&
                   (addrTen || bankSel == bstBank_ff));
  assign contAcc = edgeValid && bstActive_ff && !startAcc && !stopNow;
  assign accOn = startAcc || contAcc;
  assign accWr = startAcc ? startWr : bstWrite_ff;
  assign accBank = startAcc ? bankSel : bstBank_ff;
  assign accCol = startAcc ? row_col_addr_in[COL_BITS-1:0] :
                  burstCol(bstStart_ff, bstIdx_ff, bstLen_ff, bstIl_ff);
  assign newLen = (startWr && modeWb) ? ONE_LEN : burstLenOf(modeBl);
  assign idxNext = bstIdx_ff + ONE_LEN;
  // full page runs until stopped
  assign lastAcc = startAcc ? newLen == ONE_LEN :
                   (bstLen_ff != FULL_LEN && idxNext == bstLen_ff);
  assign closeAuto = accOn && lastAcc && (startAcc ? addrTen : bstAutoPre_ff);
  assign accIdx = memIdx(accBank, openRow_ff[accBank], accCol);

  // ----------------------------------------------------------------
  // burst engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bstActive_ff <= 1'b0;
      bstWrite_ff <= 1'b0;
      bstAutoPre_ff <= 1'b0;
      bstIl_ff <= 1'b0;
      bstBank_ff <= 2'h0;
      bstStart_ff <= '0;
      bstIdx_ff <= '0;
      bstLen_ff <= ONE_LEN;
    end else if (startAcc) begin
      bstActive_ff <= !lastAcc;
      bstWrite_ff <= startWr;
      bstAutoPre_ff <= addrTen;
      bstIl_ff <= modeIl;
      bstBank_ff <= bankSel;
      bstStart_ff <= row_col_addr_in[COL_BITS-1:0];
      bstIdx_ff <= ONE_LEN;
      bstLen_ff <= newLen;
    end else if (edgeValid && stopNow) begin
      bstActive_ff <= 1'b0;
    end else if (contAcc) begin
      bstIdx_ff <= idxNext;
      if (lastAcc) begin
        bstActive_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bank rows and mode register
  // ----------------------------------------------------------------
  // no tRP modelled: a closed bank may be reopened on the next edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rowOpen_ff <= '0;
      for (int b = 0; b < BANK_COUNT; b++) begin
        openRow_ff[b] <= '0;
      end
    end else begin
      if (cmdNow == CMD_ACTIVE) begin
        rowOpen_ff[bankSel] <= 1'b1;
        openRow_ff[bankSel] <= row_col_addr_in;
      end else if (cmdNow == CMD_PRECHARGE) begin
        if (addrTen) begin
          rowOpen_ff <= '0;
        end else begin
          rowOpen_ff[bankSel] <= 1'b0;
        end
      end
      if (closeAuto) begin
        rowOpen_ff[accBank] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_ff <= MODE_RESET;
    end else if (cmdNow == CMD_CONFIG_LOAD) begin
      modeReg_ff <= 12'(row_col_addr_in);
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  // write data is taken with the column edge itself
  always_ff @(posedge ref_clk) begin
    if (accOn && accWr) begin
      if (!low_byte_mask) begin
        mem[accIdx][HALF-1:0] <= data_io_bus_in[HALF-1:0];
      end
      if (!high_byte_mask) begin
        mem[accIdx][DATA_BITS-1:HALF] <= data_io_bus_in[DATA_BITS-1:HALF];
      end
    end
    if (accOn && !accWr) begin
      rdWord_ff <= mem[accIdx];
    end
  end

  // ----------------------------------------------------------------
  // read latency pipeline
  // ----------------------------------------------------------------
  // suspended edges freeze the pipe; mask acts one edge before the data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1Valid_ff <= 1'b0;
      p2Valid_ff <= 1'b0;
      p2Data_ff <= '0;
      outValid_ff <= 1'b0;
      data_io_bus_out <= '0;
      data_io_bus_oe <= 2'h0;
    end else if (edgeValid) begin
      p1Valid_ff <= accOn && !accWr;
      p2Valid_ff <= p1Valid_ff;
      p2Data_ff <= rdWord_ff;
      if (clIs2) begin
        outValid_ff <= p1Valid_ff;
        data_io_bus_out <= rdWord_ff;
        data_io_bus_oe <= {2{p1Valid_ff}} & ~{high_byte_mask, low_byte_mask};
      end else begin
        outValid_ff <= p2Valid_ff;
        data_io_bus_out <= p2Data_ff;
        data_io_bus_oe <= {2{p2Valid_ff}} & ~{high_byte_mask, low_byte_mask};
      end
    end
  end

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  // the state at the falling enable edge picks the low-power mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrState_ff <= PWR_RUN;
    end else if (ckePrev_ff && !cke) begin
      if (cmdNow == CMD_REFRESH) begin
        pwrState_ff <= PWR_SELF_REFRESH;
      end else if (bstActive_ff || startAcc) begin
        pwrState_ff <= PWR_SUSPEND;
      end else begin
        pwrState_ff <= PWR_DOWN;
      end
    end else if (cke) begin
      pwrState_ff <= PWR_RUN;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // answers every request one edge later; refresh count lets software
  // check the controller's refresh budget
  logic wbReq;
  logic refClear;
  logic [31:0] rdMux;
  assign wbReq = wbCycI && wbStbI;
  assign refClear = wbReq && wbWeI && wbAckO && wbAdrI == REG_REFCNT && wbSelI != 4'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCount_ff <= REFCNT_RESET;
    end else if (cmdNow == CMD_REFRESH) begin
      // a refresh in the clearing edge still counts
      refCount_ff <= refClear ? 16'h0001 : refCount_ff + 16'h0001;
    end else if (refClear) begin
      refCount_ff <= REFCNT_RESET;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (wbAdrI)
      REG_MODE: rdMux[11:0] = modeReg_ff;
      REG_STATUS: begin
        rdMux[STAT_OPEN_LSB +: BANK_COUNT] = rowOpen_ff;
        rdMux[STAT_PWR_LSB +: 2] = pwrState_ff;
        rdMux[STAT_BURST_BIT] = bstActive_ff;
      end
      REG_REFCNT: rdMux[15:0] = refCount_ff;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAckO <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAckO <= wbReq && !wbAckO;
      if (wbReq && !wbAckO) begin
        wbDatO <= rdMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_cl2_latency: assert property (
    startAcc && !startWr && clIs2 ##1 edgeValid |=> outValid_ff)
    else $error("read data missing two edges after command");
  chk_cl3_latency: assert property (
    startAcc && !startWr && !clIs2 ##1 edgeValid[*2] |=> outValid_ff)
    else $error("read data missing three edges after command");
  chk_closed_bank: assert property (
    (cmdNow == CMD_READ || cmdNow == CMD_WRITE) && !rowOpen_ff[bankSel] && !bstActive_ff
    |=> !bstActive_ff && !p1Valid_ff)
    else $error("access to a closed bank was started");
  chk_open_row: assert property (
    cmdNow == CMD_ACTIVE |=> rowOpen_ff[$past(bankSel)] &&
    openRow_ff[$past(bankSel)] == $past(row_col_addr_in))
    else $error("row not opened as addressed");
  chk_close_all: assert property (
    cmdNow == CMD_PRECHARGE && addrTen |=> rowOpen_ff == '0)
    else $error("precharge all left a bank open");
  chk_auto_close: assert property (
    startAcc && !startWr && newLen == ONE_LEN && addrTen |=> !rowOpen_ff[$past(bankSel)])
    else $error("auto precharge did not close the row");
  chk_single_write: assert property (
    startWr && modeWb |=> !bstActive_ff)
    else $error("single-write mode kept a write burst");
  chk_burst_stop: assert property (
    edgeValid && cmdNow == CMD_BURST_STOP |=> !bstActive_ff)
    else $error("burst stop ignored");
  chk_mode_load: assert property (
    cmdNow == CMD_CONFIG_LOAD |=> modeReg_ff == $past(row_col_addr_in))
    else $error("mode not stored");
  chk_deselect_hold: assert property (
    edgeValid && csN && !bstActive_ff |=> $stable(rowOpen_ff) && $stable(modeReg_ff))
    else $error("state changed while deselected");
  chk_cke_freeze: assert property (
    !edgeValid |=> $stable(bstIdx_ff) && $stable(rowOpen_ff) && $stable(data_io_bus_out))
    else $error("state moved on an invalid edge");

  cov_read_cl3: cover property (startAcc && !startWr && !clIs2 ##3 outValid_ff);
  cov_write_burst: cover property (contAcc && bstWrite_ff);
  cov_self_refresh: cover property (pwrState_ff == PWR_SELF_REFRESH);
  cov_close_all: cover property (cmdNow == CMD_PRECHARGE && addrTen);
endmodule // sdram_command_interface

/* hdl/sdram_pkg.sv */
/*
  constants and types shared by the synchronous dram command interface:
  widths, mode-register field layout, command and power-state types,
  register offsets of the wishbone side.
  assumes nothing of its surroundings.
*/
package sdram_pkg;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ROW_BITS_DEF = 12;
  localparam int COL_BITS_DEF = 8;
  localparam int DATA_BITS_DEF = 16;
  localparam int BANK_COUNT = 4;
  localparam int AUTO_CLOSE_ALL_BANKS_BIT = 10;

  // ----------------------------------------------------------------
  // mode register layout
  // ----------------------------------------------------------------
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W = 3;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_CL_W = 3;
  localparam int MODE_WB_BIT = 9;
  localparam logic [11:0] MODE_RESET = 12'h020;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [2:0] CL_CODE_TWO = 3'h2;

  // ----------------------------------------------------------------
  // wishbone register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REFCNT = 8'h08;
  localparam int STAT_OPEN_LSB = 0;
  localparam int STAT_PWR_LSB = 4;
  localparam int STAT_BURST_BIT = 8;
  localparam logic [15:0] REFCNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // refresh need of the stored data
  // ----------------------------------------------------------------
  localparam int REFRESH_CYCLES = 4096;
  localparam int REFRESH_WINDOW_MS = 64;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_CONFIG_LOAD
  } cmd_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH} pwr_t;
endpackage

/* verif/sdram_ctrl_model.sv */
/*
  controller-side driver of the dram pins: one command or one idle slot
  per call, every pin changed by non-blocking assignment after an edge.
  assumes one bench process calls its tasks and owns the clock.
*/
`timescale 1ns/10ps
module sdram_ctrl_model (
  input wire logic ref_clk,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic bankLo,
  output logic bankHi,
  output logic [11:0] addr,
  output logic [15:0] dat,
  output logic maskLo,
  output logic maskHi
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // idle and selected-off at time zero so reset sees no command
  initial begin
    cke = 1'b1;
    csN = 1'b1;
    {rasN, casN, weN} = 3'h7;
    {bankHi, bankLo, addr, dat, maskHi, maskLo} = '0;
  end

  // strobes follow the usual truth table; everything held until the next call
  task automatic cmd(input logic cs, input logic [2:0] c, input logic [1:0] b,
      input logic [11:0] a, input logic [15:0] d, input logic [1:0] m);
    @(posedge ref_clk);
    csN <= cs;
    {rasN, casN, weN} <= c;
    {bankHi, bankLo} <= b;
    addr <= a;
    dat <= d;
    {maskHi, maskLo} <= m;
  endtask

  // idle slot: address toggles so a stale value is never read as valid
  task automatic nop(input logic [15:0] d, input logic [1:0] m);
    @(posedge ref_clk);
    csN <= 1'b1;
    {rasN, casN, weN} <= 3'h7;
    addr <= ~addr;
    dat <= d;
    {maskHi, maskLo} <= m;
  endtask

  // clock enable changes in the caller's time step, next to a command
  task automatic setCke(input logic v);
    cke <= v;
  endtask
endmodule // sdram_ctrl_model

/* verif/sdram_command_interface_bench.sv */
/*
  self-checking bench: random bursts over lengths 1, 2, 4 and 8, order, latency
  and write mode, then select, clock-enable, refresh and register corners.
  assumes sdram_pkg and the controller model are compiled before it.
*/
`timescale 1ns/10ps
module sdram_command_interface_bench;
  import sdram_pkg::*;
  localparam logic [11:0] ALL = 12'h001 << AUTO_CLOSE_ALL_BANKS_BIT;
  logic ref_clk, rst_n, cke, csN, rasN, casN, weN, bLo, bHi, lm, hm;
  logic [11:0] addr;
  logic [15:0] dIn, dOut;
  logic [1:0] oe;
  logic wbWeI, wbCycI, wbStbI, wbAckO;
  logic [7:0] wbAdrI;
  logic [3:0] wbSelI;
  logic [31:0] wbDatI, wbDatO, q;
  int failCount, cmpCount, edgeNo, tick, seed, rdEdge;
  logic [15:0] refMem [int];
  logic [15:0] capD [$];
  logic [1:0] capO [$];
  int capE [$];

  sdram_command_interface dut (.ref_clk(ref_clk), .rst_n(rst_n), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bank_select_lo(bLo), .bank_select_hi(bHi),
    .row_col_addr_in(addr), .data_io_bus_in(dIn), .data_io_bus_out(dOut),
    .data_io_bus_oe(oe), .low_byte_mask(lm), .high_byte_mask(hm), .wbAdrI(wbAdrI),
    .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbDatO(wbDatO), .wbAckO(wbAckO));
  sdram_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankLo(bLo), .bankHi(bHi), .addr(addr), .dat(dIn),
    .maskLo(lm), .maskHi(hm));

  // ----------------------------------------------------------------
  // clock, edge count, timeout and read capture
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // the run needs under a thousand cycles; a hang is cut well beyond that
  always @(posedge ref_clk) begin
    edgeNo <= edgeNo + 1;
    tick <= tick + 1;
    if (tick == 20000) begin
      failCount++;
      print_verdict();
    end
  end
  // every driven beat is kept with the edge it was seen at
  always @(posedge ref_clk) if (oe !== 2'h0) begin
    capD.push_back(dOut);
    capO.push_back(oe);
    capE.push_back(edgeNo);
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic cycle: request held until ack is sampled; the timeout bounds the wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= a;
    wbDatI <= d;
    wbSelI <= 4'hf;
    do @(posedge ref_clk); while (wbAckO !== 1'b1);
    q = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  // column of beat i inside the aligned block of the burst
  function automatic logic [7:0] colAt(logic [7:0] s, int i, int len, logic il);
    logic [7:0] m;
    m = 8'(len - 1);
    return il ? (s & ~m) | ((s ^ 8'(i)) & m) : (s & ~m) | ((s + 8'(i)) & m);
  endfunction
  // never-written words stay unknown, as the array is not reset
  function automatic logic [15:0] memAt(logic [1:0] b, logic [11:0] r, logic [7:0] c);
    return refMem.exists(int'({b, r, c})) ? refMem[int'({b, r, c})] : 16'hxxxx;
  endfunction
  task automatic print_verdict();
    if (failCount == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [1:0] bk, rdM, m;
    logic [11:0] row, md;
    logic [7:0] sc;
    logic [15:0] d, e, bm;
    logic [2:0] cl;
    logic il, sw, ap;
    int len, lat;
    seed = 32'h8719;
    rst_n = 1'b0;
    {wbCycI, wbStbI, wbWeI, wbAdrI, wbDatI} = '0;
    wbSelI = 4'hf;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdChk(REG_MODE, 32'(MODE_RESET));
    rdChk(REG_REFCNT, 32'(REFCNT_RESET));
    // each of lengths 1, 2, 4 and 8, order, latency and write mode once, random place and data
    for (int it = 0; it < 32; it++) begin
      il = it[2];
      sw = it[4];
      cl = it[3] ? 3'h3 : 3'h2;
      lat = it[3] ? 3 : 2;
      len = 1 << it[1:0];
      md = {2'h0, sw, 2'h0, cl, il, 1'b0, it[1:0]};
      ctl.cmd(1'b0, 3'h0, 2'h0, md, 16'h0, 2'h0);
      ctl.cmd(1'b0, 3'h2, 2'h0, ALL, 16'h0, 2'h0);
      {bk, row, sc, ap} = 23'($random(seed));
      ctl.cmd(1'b0, 3'h3, bk, row, 16'h0, 2'h0);
      for (int i = 0; i < len; i++) begin
        {d, m} = 18'($random(seed));
        e = memAt(bk, row, colAt(sc, i, len, il));
        if (i == 0 || !sw) refMem[int'({bk, row, colAt(sc, i, len, il)})] =
          {m[1] ? e[15:8] : d[15:8], m[0] ? e[7:0] : d[7:0]};
        if (i == 0) ctl.cmd(1'b0, 3'h4, bk, {4'h0, sc}, d, m);
        else ctl.nop(d, m);
      end
      rdM = 2'(it % 3);
      ctl.cmd(1'b0, 3'h5, bk, {1'b0, ap, 2'h0, sc}, 16'h0, rdM);
      rdEdge = edgeNo + 1;
      repeat (len + lat + 2) ctl.nop(16'h0, rdM);
      check(capD.size(), len);
      bm = {{8{~rdM[1]}}, {8{~rdM[0]}}};
      for (int i = 0; i < capD.size() && i < len; i++) begin
        e = memAt(bk, row, colAt(sc, i, len, il));
        check(capD[i] & bm, e & bm);
        check(capO[i], 2'(~rdM));
        check(capE[i], rdEdge + lat + i);
      end
      capD.delete();
      capO.delete();
      capE.delete();
      rdChk(REG_STATUS, ap ? 32'h0 : 32'h1 << bk);
    end
    // deselected open and a read of a closed bank leave no trace
    ctl.cmd(1'b0, 3'h2, 2'h0, ALL, 16'h0, 2'h0);
    ctl.cmd(1'b1, 3'h3, 2'h1, 12'h005, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h5, 2'h2, 12'h000, 16'h0, 2'h0);
    repeat (5) ctl.nop(16'h0, 2'h0);
    check(capD.size(), 0);
    rdChk(REG_STATUS, 32'h0);
    // enable low while idle: power-down, and the open on the next edge is void
    ctl.setCke(1'b0);
    ctl.cmd(1'b0, 3'h3, 2'h3, 12'h001, 16'h0, 2'h0);
    ctl.nop(16'h0, 2'h0);
    rdChk(REG_STATUS, 32'h10);
    ctl.setCke(1'b1);
    repeat (2) ctl.cmd(1'b0, 3'h1, 2'h0, 12'h000, 16'h0, 2'h0);
    // refresh with enable falling in the same slot enters self refresh
    ctl.cmd(1'b0, 3'h1, 2'h0, 12'h000, 16'h0, 2'h0);
    ctl.setCke(1'b0);
    rdChk(REG_STATUS, 32'h30);
    rdChk(REG_REFCNT, 32'h3);
    ctl.setCke(1'b1);
    repeat (2) ctl.nop(16'h0, 2'h0);
    wb(1'b1, REG_REFCNT, 32'h0);
    rdChk(REG_REFCNT, 32'h0);
    // idle bank closed under a burst, burst stop cuts it, new column every edge
    md = 12'h023;
    ctl.cmd(1'b0, 3'h0, 2'h0, md, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h3, 2'h0, 12'h000, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h3, 2'h1, 12'h000, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h5, 2'h0, 12'h000, 16'h0, 2'h0);
    rdEdge = edgeNo + 1;
    ctl.cmd(1'b0, 3'h2, 2'h1, 12'h000, 16'h0, 2'h0);
    ctl.nop(16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h6, 2'h0, 12'h000, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h5, 2'h0, 12'h005, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h5, 2'h0, 12'h009, 16'h0, 2'h0);
    ctl.cmd(1'b0, 3'h6, 2'h0, 12'h000, 16'h0, 2'h0);
    repeat (4) ctl.nop(16'h0, 2'h0);
    check(capD.size(), 5);
    check(capE[0], rdEdge + 2);
    check(capE[3] - capE[0], 4);
    capD.delete();
    capO.delete();
    capE.delete();
    rdChk(REG_STATUS, 32'h1);
    wb(1'b1, REG_MODE, 32'hfff);
    rdChk(REG_MODE, 32'(md));
    // unmapped place reads zero
    rdChk(8'h0c, 32'h0);
    print_verdict();
  end
endmodule // sdram_command_interface_bench
